/* File: cpu_core_pkg.sv */
package cpu_core_pkg;

  // ==========================================================================
  // Opcodes handled by this group
  // ==========================================================================
  localparam logic [7:0] OPC_TRAP = 8'h83;
  localparam logic [7:0] OPC_ACC_TO_FLAGS = 8'h84;
  localparam logic [7:0] OPC_FLAGS_TO_ACC = 8'h85;
  localparam logic [7:0] OPC_IDX_TO_STK = 8'h94;
  localparam logic [7:0] OPC_STK_TO_IDX = 8'h95;
  localparam logic [7:0] OPC_ACC_TO_IDX = 8'h97;
  localparam logic [7:0] OPC_IDX_TO_ACC = 8'h9F;
  localparam logic [7:0] OPC_PREFIX = 8'h9E;
  localparam logic [7:0] OPC_CHECK_DIR = 8'h3D;
  localparam logic [7:0] OPC_CHECK_ACC = 8'h4D;
  localparam logic [7:0] OPC_CHECK_IDX = 8'h5D;
  localparam logic [7:0] OPC_CHECK_IX_SHORT = 8'h6D;
  localparam logic [7:0] OPC_CHECK_IX = 8'h7D;
  localparam logic [7:0] OPC_CHECK_SP_SHORT = 8'h6D;
  localparam logic [7:0] OPC_MOVE_DD = 8'h4E;
  localparam logic [7:0] OPC_MOVE_D_PI = 8'h5E;
  localparam logic [7:0] OPC_MOVE_IMD = 8'h6E;
  localparam logic [7:0] OPC_MOVE_PI_D = 8'h7E;
  localparam logic [3:0] OPC_BRB_GROUP = 4'h0;

  // ==========================================================================
  // Cycle counts per opcode
  // ==========================================================================
  localparam logic [3:0] CYC_ONE = 4'd1;
  localparam logic [3:0] CYC_TWO = 4'd2;
  localparam logic [3:0] CYC_TRAP = 4'd9;
  localparam logic [3:0] CYC_CHECK_DIR = 4'd3;
  localparam logic [3:0] CYC_CHECK_IX_SHORT = 4'd3;
  localparam logic [3:0] CYC_CHECK_IX = 4'd2;
  localparam logic [3:0] CYC_CHECK_SP_SHORT = 4'd4;
  localparam logic [3:0] CYC_MOVE_DD = 4'd5;
  localparam logic [3:0] CYC_MOVE_OTHER = 4'd4;
  localparam logic [3:0] CYC_BRB = 4'd5;
  localparam logic [3:0] TRAP_LAST_PUSH = 4'd5;
  localparam logic [3:0] TRAP_VEC_HI = 4'd6;

  // ==========================================================================
  // Flag layout, vector and reset values
  // ==========================================================================
  localparam int CCR_V = 7;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [15:0] TRAP_VECTOR = 16'hFFFC;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h00FF;
  localparam logic [7:0] RST_FLAGS = 8'h68;

  // ==========================================================================
  // Avalon register map (byte addresses)
  // ==========================================================================
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_PC = 5'h08;
  localparam logic [4:0] REG_SP = 5'h0C;
  localparam logic [4:0] REG_CORE = 5'h10;
  localparam int CTRL_RUN = 0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    inherent_mode, direct_mode, extended_mode, indexed_mode,
    indexed_short_offset_mode, indexed_long_offset_mode, indexed_postinc_mode,
    postinc_short_offset_mode, stack_offset_short_mode, stack_offset_long_mode,
    immediate_to_direct_mode, direct_to_direct_mode, postinc_to_direct_mode,
    direct_to_postinc_mode
  } addr_mode_e;

  typedef enum logic [3:0] {
    K_NOP, K_TRAP, K_CHECK_ACC, K_CHECK_IDX, K_CHECK_MEM, K_ACC_TO_FLAGS,
    K_FLAGS_TO_ACC, K_ACC_TO_IDX, K_IDX_TO_ACC, K_STK_TO_IDX, K_IDX_TO_STK,
    K_MOVE, K_BRB
  } op_kind_e;

  typedef struct packed {
    op_kind_e kind;
    addr_mode_e mode;
    logic [3:0] cycles;
    logic [1:0] nbytes;
  } decode_s;

endpackage

/* File: ea_if.sv */
`timescale 1ns/1ps
// Carries the operand fields to the address calculator and the address back.
interface ea_if;
  cpu_core_pkg::addr_mode_e mode;
  logic [15:0] hx;
  logic [15:0] sp;
  logic [7:0] b1;
  logic [7:0] b2;
  logic dst;
  logic [15:0] addr;
  modport calc (input mode, input hx, input sp, input b1, input b2, input dst, output addr);
  modport user (output mode, output hx, output sp, output b1, output b2, output dst,
                input addr);
endinterface

/* File: ea_calc.sv */
`timescale 1ns/1ps
module ea_calc (
  ea_if.calc port
);

  // ==========================================================================
  // Effective address
  // ==========================================================================
  // Pure combinational; b1 is the first operand byte, b2 the second.
  always_comb
  begin
    case (port.mode)
      cpu_core_pkg::direct_mode: port.addr = {8'h00, port.b1};
      cpu_core_pkg::extended_mode: port.addr = {port.b1, port.b2};
      cpu_core_pkg::indexed_mode: port.addr = port.hx;
      cpu_core_pkg::indexed_short_offset_mode: port.addr = port.hx + {8'h00, port.b1};
      cpu_core_pkg::indexed_long_offset_mode: port.addr = port.hx + {port.b1, port.b2};
      cpu_core_pkg::indexed_postinc_mode: port.addr = port.hx;
      cpu_core_pkg::postinc_short_offset_mode: port.addr = port.hx + {8'h00, port.b1};
      cpu_core_pkg::stack_offset_short_mode: port.addr = port.sp + {8'h00, port.b1};
      cpu_core_pkg::stack_offset_long_mode: port.addr = port.sp + {port.b1, port.b2};
      cpu_core_pkg::immediate_to_direct_mode: port.addr = {8'h00, port.b2};
      cpu_core_pkg::direct_to_direct_mode:
        port.addr = port.dst ? {8'h00, port.b2} : {8'h00, port.b1};
      cpu_core_pkg::postinc_to_direct_mode: port.addr = port.dst ? {8'h00, port.b1} : port.hx;
      cpu_core_pkg::direct_to_postinc_mode: port.addr = port.dst ? port.hx : {8'h00, port.b1};
      default: port.addr = 16'h0000;
    endcase
  end

endmodule // ea_calc

/* File: cpu_xfer_core.sv */
`timescale 1ns/1ps
// Overview of operation
// - trap pushes return address, index low, accumulator, flags; masks; loads vector.
// - check sets negative and zero, clears overflow, keeps other flags.
// - none, one or two operand bytes follow the opcode, per addressing mode.
// - stack forms add an unsigned one or two byte offset to stack pointer.
// - indexed forms add none, one byte or two byte offset, high first.
// - post-increment forms address via index pair, then bump it by one.
// - extended address is two bytes, high byte first.
// - four memory-to-memory move forms are executed.
// - bit branch takes direct address then signed displacement added to PC.
// - index pair is high byte concatenated with index low byte.
module cpu_xfer_core (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [15:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata
);

  typedef enum logic [3:0] {
    ST_FETCH, ST_PREFIX, ST_BYTE1, ST_BYTE2, ST_READ, ST_WRITE, ST_PUSH, ST_VECTOR, ST_PAD
  } seq_state_e;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Opcode decode, used on the fetched byte and on the stored opcode.
  function automatic cpu_core_pkg::decode_s decode(input logic [7:0] op, input logic pre);
    cpu_core_pkg::decode_s d;
    d = '{cpu_core_pkg::K_NOP, cpu_core_pkg::inherent_mode, cpu_core_pkg::CYC_ONE, 2'd0};
    if (pre)
    begin
      if (op == cpu_core_pkg::OPC_CHECK_SP_SHORT)
        d = '{cpu_core_pkg::K_CHECK_MEM, cpu_core_pkg::stack_offset_short_mode,
              cpu_core_pkg::CYC_CHECK_SP_SHORT, 2'd1};
      else
        d.cycles = cpu_core_pkg::CYC_TWO;
    end
    else if (op[7:4] == cpu_core_pkg::OPC_BRB_GROUP)
      d = '{cpu_core_pkg::K_BRB, cpu_core_pkg::direct_mode, cpu_core_pkg::CYC_BRB, 2'd2};
    else
    begin
      case (op)
        cpu_core_pkg::OPC_TRAP:
          d = '{cpu_core_pkg::K_TRAP, cpu_core_pkg::inherent_mode, cpu_core_pkg::CYC_TRAP, 2'd0};
        cpu_core_pkg::OPC_ACC_TO_FLAGS: d = '{cpu_core_pkg::K_ACC_TO_FLAGS,
          cpu_core_pkg::inherent_mode, cpu_core_pkg::CYC_TWO, 2'd0};
        cpu_core_pkg::OPC_FLAGS_TO_ACC: d.kind = cpu_core_pkg::K_FLAGS_TO_ACC;
        cpu_core_pkg::OPC_ACC_TO_IDX: d.kind = cpu_core_pkg::K_ACC_TO_IDX;
        cpu_core_pkg::OPC_IDX_TO_ACC: d.kind = cpu_core_pkg::K_IDX_TO_ACC;
        cpu_core_pkg::OPC_STK_TO_IDX: d = '{cpu_core_pkg::K_STK_TO_IDX,
          cpu_core_pkg::inherent_mode, cpu_core_pkg::CYC_TWO, 2'd0};
        cpu_core_pkg::OPC_IDX_TO_STK: d = '{cpu_core_pkg::K_IDX_TO_STK,
          cpu_core_pkg::inherent_mode, cpu_core_pkg::CYC_TWO, 2'd0};
        cpu_core_pkg::OPC_CHECK_ACC: d.kind = cpu_core_pkg::K_CHECK_ACC;
        cpu_core_pkg::OPC_CHECK_IDX: d.kind = cpu_core_pkg::K_CHECK_IDX;
        cpu_core_pkg::OPC_CHECK_DIR: d = '{cpu_core_pkg::K_CHECK_MEM,
          cpu_core_pkg::direct_mode, cpu_core_pkg::CYC_CHECK_DIR, 2'd1};
        cpu_core_pkg::OPC_CHECK_IX_SHORT: d = '{cpu_core_pkg::K_CHECK_MEM,
          cpu_core_pkg::indexed_short_offset_mode, cpu_core_pkg::CYC_CHECK_IX_SHORT, 2'd1};
        cpu_core_pkg::OPC_CHECK_IX: d = '{cpu_core_pkg::K_CHECK_MEM,
          cpu_core_pkg::indexed_mode, cpu_core_pkg::CYC_CHECK_IX, 2'd0};
        cpu_core_pkg::OPC_MOVE_DD: d = '{cpu_core_pkg::K_MOVE,
          cpu_core_pkg::direct_to_direct_mode, cpu_core_pkg::CYC_MOVE_DD, 2'd2};
        cpu_core_pkg::OPC_MOVE_IMD: d = '{cpu_core_pkg::K_MOVE,
          cpu_core_pkg::immediate_to_direct_mode, cpu_core_pkg::CYC_MOVE_OTHER, 2'd2};
        cpu_core_pkg::OPC_MOVE_PI_D: d = '{cpu_core_pkg::K_MOVE,
          cpu_core_pkg::postinc_to_direct_mode, cpu_core_pkg::CYC_MOVE_OTHER, 2'd1};
        cpu_core_pkg::OPC_MOVE_D_PI: d = '{cpu_core_pkg::K_MOVE,
          cpu_core_pkg::direct_to_postinc_mode, cpu_core_pkg::CYC_MOVE_OTHER, 2'd1};
        default: d.kind = cpu_core_pkg::K_NOP;
      endcase
    end
    return d;
  endfunction

  // Negative and zero from a value, overflow cleared, the rest kept.
  function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
    logic [7:0] r;
    r = f;
    r[cpu_core_pkg::CCR_V] = 1'b0;
    r[cpu_core_pkg::CCR_N] = v[7];
    r[cpu_core_pkg::CCR_Z] = (v == 8'h00);
    return r;
  endfunction

  // Byte-lane merge for Avalon writes.
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  seq_state_e st_q, st_d;
  logic [3:0] cyc_q, cyc_d;
  logic [15:0] pc_q, pc_d, sp_q, sp_d;
  logic [7:0] a_q, a_d, x_q, x_d, h_q, h_d, ccr_q, ccr_d;
  logic [7:0] opc_q, opc_d, b1_q, b1_d, b2_q, b2_d, data_q, data_d;
  logic pre_q, pre_d, run_q, run_d, ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  cpu_core_pkg::decode_s cur_dec;
  logic [15:0] hx;
  logic halted;
  ea_if ea ();

  assign hx = {h_q, x_q};
  assign cur_dec = decode(opc_q, pre_q);
  assign halted = (st_q == ST_FETCH) && !run_q;
  assign ea.mode = cur_dec.mode;
  assign ea.hx = hx;
  assign ea.sp = sp_q;
  assign ea.b1 = b1_q;
  assign ea.b2 = b2_q;
  assign ea.dst = (st_q == ST_WRITE);

  ea_calc u_ea (
    .port (ea.calc)
  );

  // ==========================================================================
  // Avalon slave
  // ==========================================================================
  // One wait cycle on every access keeps read data registered.
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_readdata = rdata_q;

  // ==========================================================================
  // Sequencer and datapath
  // ==========================================================================
  // Memory is read in the same cycle its address is presented.
  always_comb
  begin
    cpu_core_pkg::decode_s dc;
    logic fin;
    logic [31:0] m;
    logic bitv;
    dc = cur_dec;
    fin = 1'b0;
    m = 32'h0000_0000;
    bitv = 1'b0;
    st_d = st_q;
    pc_d = pc_q;
    sp_d = sp_q;
    a_d = a_q;
    x_d = x_q;
    h_d = h_q;
    ccr_d = ccr_q;
    opc_d = opc_q;
    b1_d = b1_q;
    b2_d = b2_q;
    data_d = data_q;
    pre_d = pre_q;
    run_d = run_q;
    o_mem_addr = pc_q;
    o_mem_rd = 1'b0;
    o_mem_wr = 1'b0;
    o_mem_wdata = 8'h00;
    case (st_q)
      ST_FETCH, ST_PREFIX:
      begin
        if (run_q || st_q == ST_PREFIX)
        begin
          o_mem_rd = 1'b1;
          pc_d = pc_q + 16'h0001;
          opc_d = i_mem_rdata;
          if (st_q == ST_FETCH && i_mem_rdata == cpu_core_pkg::OPC_PREFIX)
          begin
            pre_d = 1'b1;
            st_d = ST_PREFIX;
          end
          else
          begin
            dc = decode(i_mem_rdata, st_q == ST_PREFIX);
            pre_d = (st_q == ST_PREFIX);
            if (dc.nbytes != 2'd0)
              st_d = ST_BYTE1;
            else if (dc.kind == cpu_core_pkg::K_CHECK_MEM)
              st_d = ST_READ;
            else if (dc.kind == cpu_core_pkg::K_TRAP)
              st_d = ST_PUSH;
            else
            begin
              fin = 1'b1;
              case (dc.kind)
                cpu_core_pkg::K_CHECK_ACC: ccr_d = nz_flags(ccr_q, a_q);
                cpu_core_pkg::K_CHECK_IDX: ccr_d = nz_flags(ccr_q, x_q);
                cpu_core_pkg::K_ACC_TO_FLAGS: ccr_d = a_q | cpu_core_pkg::FLAGS_ONES;
                cpu_core_pkg::K_FLAGS_TO_ACC: a_d = ccr_q;
                cpu_core_pkg::K_ACC_TO_IDX: x_d = a_q;
                cpu_core_pkg::K_IDX_TO_ACC: a_d = x_q;
                cpu_core_pkg::K_STK_TO_IDX: {h_d, x_d} = sp_q + 16'h0001;
                cpu_core_pkg::K_IDX_TO_STK: sp_d = hx - 16'h0001;
                default: fin = 1'b1;
              endcase
            end
          end
        end
      end
      ST_BYTE1, ST_BYTE2:
      begin
        o_mem_rd = 1'b1;
        pc_d = pc_q + 16'h0001;
        if (st_q == ST_BYTE1)
          b1_d = i_mem_rdata;
        else
          b2_d = i_mem_rdata;
        if (st_q == ST_BYTE1 && cur_dec.nbytes == 2'd2)
          st_d = ST_BYTE2;
        else if (cur_dec.mode == cpu_core_pkg::immediate_to_direct_mode)
        begin
          data_d = b1_q;
          st_d = ST_WRITE;
        end
        else
          st_d = ST_READ;
      end
      ST_READ:
      begin
        o_mem_rd = 1'b1;
        o_mem_addr = ea.addr;
        data_d = i_mem_rdata;
        case (cur_dec.kind)
          cpu_core_pkg::K_MOVE:
          begin
            st_d = ST_WRITE;
            if (cur_dec.mode == cpu_core_pkg::postinc_to_direct_mode)
              {h_d, x_d} = hx + 16'h0001;
          end
          cpu_core_pkg::K_BRB:
          begin
            fin = 1'b1;
            bitv = i_mem_rdata[opc_q[3:1]];
            ccr_d[cpu_core_pkg::CCR_C] = bitv;
            if (bitv ^ opc_q[0])
              pc_d = pc_q + {{8{b2_q[7]}}, b2_q};
          end
          default:
          begin
            fin = 1'b1;
            ccr_d = nz_flags(ccr_q, i_mem_rdata);
          end
        endcase
      end
      ST_WRITE:
      begin
        o_mem_wr = 1'b1;
        o_mem_addr = ea.addr;
        o_mem_wdata = data_q;
        ccr_d = nz_flags(ccr_q, data_q);
        fin = 1'b1;
        if (cur_dec.mode == cpu_core_pkg::direct_to_postinc_mode)
          {h_d, x_d} = hx + 16'h0001;
      end
      ST_PUSH:
      begin
        o_mem_wr = 1'b1;
        o_mem_addr = sp_q;
        sp_d = sp_q - 16'h0001;
        case (cyc_q)
          4'd1: o_mem_wdata = pc_q[7:0];
          4'd2: o_mem_wdata = pc_q[15:8];
          4'd3: o_mem_wdata = x_q;
          4'd4: o_mem_wdata = a_q;
          default: o_mem_wdata = ccr_q;
        endcase
        if (cyc_q == cpu_core_pkg::TRAP_LAST_PUSH)
        begin
          ccr_d[cpu_core_pkg::CCR_I] = 1'b1;
          st_d = ST_VECTOR;
        end
      end
      ST_VECTOR:
      begin
        o_mem_rd = 1'b1;
        if (cyc_q == cpu_core_pkg::TRAP_VEC_HI)
        begin
          o_mem_addr = cpu_core_pkg::TRAP_VECTOR;
          pc_d = {i_mem_rdata, pc_q[7:0]};
        end
        else
        begin
          o_mem_addr = cpu_core_pkg::TRAP_VECTOR + 16'h0001;
          pc_d = {pc_q[15:8], i_mem_rdata};
          fin = 1'b1;
        end
      end
      ST_PAD: fin = 1'b1;
      default: st_d = ST_FETCH;
    endcase
    if (fin)
      st_d = (cyc_q + 4'd1 >= dc.cycles) ? ST_FETCH : ST_PAD;
    cyc_d = (st_d == ST_FETCH) ? 4'd0 : cyc_q + 4'd1;

    // Software may change core registers only while the core is parked.
    if (i_avs_write && ack_q)
    begin
      case (i_avs_address)
        cpu_core_pkg::REG_CTRL:
        begin
          m = merge_be({31'h0, run_q}, i_avs_writedata, i_avs_byteenable);
          run_d = m[cpu_core_pkg::CTRL_RUN];
        end
        cpu_core_pkg::REG_PC:
        begin
          m = merge_be({16'h0000, pc_q}, i_avs_writedata, i_avs_byteenable);
          if (halted)
            pc_d = m[15:0];
        end
        cpu_core_pkg::REG_SP:
        begin
          m = merge_be({16'h0000, sp_q}, i_avs_writedata, i_avs_byteenable);
          if (halted)
            sp_d = m[15:0];
        end
        cpu_core_pkg::REG_CORE:
        begin
          m = merge_be({ccr_q, h_q, x_q, a_q}, i_avs_writedata, i_avs_byteenable);
          if (halted)
          begin
            a_d = m[7:0];
            x_d = m[15:8];
            h_d = m[23:16];
            ccr_d = m[31:24] | cpu_core_pkg::FLAGS_ONES;
          end
        end
        default: m = 32'h0000_0000;
      endcase
    end
  end

  // Bus acknowledge and read mux; unmapped addresses read zero.
  always_comb
  begin
    ack_d = (i_avs_read || i_avs_write) && !ack_q;
    rdata_d = rdata_q;
    if (i_avs_read && !ack_q)
    begin
      case (i_avs_address)
        cpu_core_pkg::REG_CTRL: rdata_d = {31'h0, run_q};
        cpu_core_pkg::REG_STATUS: rdata_d = {16'h0000, ccr_q, 6'h00, halted, st_q != ST_FETCH};
        cpu_core_pkg::REG_PC: rdata_d = {16'h0000, pc_q};
        cpu_core_pkg::REG_SP: rdata_d = {16'h0000, sp_q};
        cpu_core_pkg::REG_CORE: rdata_d = {ccr_q, h_q, x_q, a_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= ST_FETCH;
      cyc_q <= 4'd0;
      pc_q <= cpu_core_pkg::RST_PC;
      sp_q <= cpu_core_pkg::RST_SP;
      a_q <= 8'h00;
      x_q <= 8'h00;
      h_q <= 8'h00;
      ccr_q <= cpu_core_pkg::RST_FLAGS;
      opc_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      data_q <= 8'h00;
      pre_q <= 1'b0;
      run_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      a_q <= a_d;
      x_q <= x_d;
      h_q <= h_d;
      ccr_q <= ccr_d;
      opc_q <= opc_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      data_q <= data_d;
      pre_q <= pre_d;
      run_q <= run_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

endmodule // cpu_xfer_core

/* File: cpu_xfer_mem.sv */
`timescale 1ns/1ps
// ==========================================
// Zero-latency byte memory on the far side
// ==========================================
// A cycle without a read shows a toggling pattern, so the core cannot lean on stale data.
module cpu_xfer_mem (
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk = 8'hA5;
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
  end
  // A write lands on the edge that closes its cycle.
  always @(posedge i_clk)
  begin
    junk <= ~junk;
    if (i_wr)
      mem[i_addr] <= i_wdata;
  end
  assign o_rdata = i_rd ? mem[i_addr] : junk;
endmodule // cpu_xfer_mem

/* File: cpu_xfer_core_checker.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker for the transfer core
// ==========================================
module cpu_xfer_core_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [15:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Bus timing is fixed, so software can count on it.
  property p_wait; $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait state wrong");
  property p_idle; !(i_avs_read | i_avs_write) |-> !o_avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait raised while idle");
  property p_excl; !(o_mem_rd && o_mem_wr); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_wdata; !o_mem_wr |-> o_mem_wdata == 8'h00; endproperty
  a_wdata: assert property (p_wdata) else $error("write byte without write");
  property p_push; o_mem_wr ##1 o_mem_wr |-> o_mem_addr == $past(o_mem_addr) - 16'h0001; endproperty
  a_push: assert property (p_push) else $error("push address not falling");
  property p_vec; o_mem_wr [*5] |=> o_mem_rd && o_mem_addr == cpu_core_pkg::TRAP_VECTOR
    ##1 o_mem_rd && o_mem_addr == 16'hFFFD; endproperty
  a_vec: assert property (p_vec) else $error("vector fetch wrong");
  property p_trap; o_mem_rd && i_mem_rdata == cpu_core_pkg::OPC_TRAP
    |=> o_mem_wr [*5] ##1 o_mem_rd [*2] ##1 !o_mem_rd; endproperty
  a_trap: assert property (p_trap) else $error("trap sequence wrong");
  property p_dir; o_mem_rd && i_mem_rdata == 8'h3D
    |=> o_mem_rd ##1 (o_mem_rd && o_mem_addr == {8'h00, $past(i_mem_rdata)}); endproperty
  a_dir: assert property (p_dir) else $error("direct check access wrong");
  c_push: cover property (o_mem_wr [*5]);
  c_wr: cover property ($rose(i_avs_write));
  c_dir: cover property (o_mem_rd && i_mem_rdata == 8'h3D);
endmodule // cpu_xfer_core_checker
bind cpu_xfer_core cpu_xfer_core_checker chk_u (.*);

/* File: cpu_xfer_core_tb_top.sv */
`timescale 1ns/1ps
// ==========================================
// Testbench: programs run from memory
// ==========================================
module cpu_xfer_core_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, q;
  logic wt, mrd, mwr;
  logic [15:0] madr;
  logic [7:0] mwd, mrdat;
  int mismatches = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  cpu_xfer_core dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wt), .o_mem_addr(madr), .o_mem_rd(mrd), .o_mem_wr(mwr),
    .o_mem_wdata(mwd), .i_mem_rdata(mrdat));
  cpu_xfer_mem mem_u (.i_clk(clk), .i_addr(madr), .i_rd(mrd), .i_wr(mwr), .i_wdata(mwd),
    .o_rdata(mrdat));
  // One bus access; the request stands until waitrequest is seen low.
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Load state while parked, run, then park again between instructions.
  task automatic run_prog(input logic [15:0] pc, input logic [31:0] core);
    av(1'b1, cpu_core_pkg::REG_PC, {16'h0, pc});
    av(1'b1, cpu_core_pkg::REG_SP, 32'h0000_00FF);
    av(1'b1, cpu_core_pkg::REG_CORE, core);
    av(1'b1, cpu_core_pkg::REG_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    av(1'b1, cpu_core_pkg::REG_CTRL, 32'h0);
    do av(1'b0, cpu_core_pkg::REG_STATUS, 32'h0); while (q[1] !== 1'b1);
  endtask
  task automatic regs(input logic [15:0] pc, input logic [15:0] sp, input logic [31:0] core);
    av(1'b0, cpu_core_pkg::REG_PC, 32'h0);
    chk("pc", {16'h0, pc}, {16'h0, q[15:0]});
    av(1'b0, cpu_core_pkg::REG_SP, 32'h0);
    chk("sp", {16'h0, sp}, {16'h0, q[15:0]});
    av(1'b0, cpu_core_pkg::REG_CORE, 32'h0);
    chk("core", core, q);
  endtask
  // Trap at 0123, vector to a bit-branch self loop at 0200.
  task automatic t_trap;
    mem_u.mem[16'h0123] = 8'h83;
    mem_u.mem[16'hFFFC] = 8'h02;
    mem_u.mem[16'h0201] = 8'hF0;
    mem_u.mem[16'h0202] = 8'hFD;
    mem_u.mem[16'h00F0] = 8'h01;
    run_prog(16'h0123, 32'h6012_345A);
    regs(16'h0200, 16'h00FA, 32'h6912_345A);
    chk("push", 32'h2401_345A, {mem_u.mem[255], mem_u.mem[254], mem_u.mem[253], mem_u.mem[252]});
    chk("push_flags", 32'h60, {24'h0, mem_u.mem[251]});
    $display("trap test done");
  endtask
  // Direct and stack checks around register transfers, then an unmapped read.
  task automatic t_check;
    logic [7:0] p [11] = '{8'h3D, 8'h80, 8'h85, 8'h97, 8'h95, 8'h9E, 8'h6D, 8'h02, 8'h00,
      8'hF0, 8'hFD};
    for (int i = 0; i < 11; i++)
      mem_u.mem[16'h0300 + i] = p[i];
    mem_u.mem[16'h0080] = 8'h80;
    run_prog(16'h0300, 32'hF900_0000);
    regs(16'h0308, 16'h00FF, 32'h7B01_007D);
    av(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("check test done");
  endtask
  // Moves and the remaining register forms, then the same bit-branch self loop.
  task automatic t_move;
    logic [7:0] p [21] = '{8'h4D, 8'h6E, 8'h55, 8'h20, 8'h4E, 8'h20, 8'h21, 8'h7E, 8'h22,
      8'h5E, 8'h21, 8'h6D, 8'h01, 8'h7D, 8'h5D, 8'h9F, 8'h94, 8'h84, 8'h00, 8'hF0, 8'hFD};
    for (int i = 0; i < 21; i++)
      mem_u.mem[16'h0400 + i] = p[i];
    mem_u.mem[16'h0010] = 8'h9C;
    run_prog(16'h0400, 32'h6000_1080);
    regs(16'h0412, 16'h0011, 32'h7300_1212);
    chk("moved", 32'h5555_9C55, {mem_u.mem[32], mem_u.mem[33], mem_u.mem[34], mem_u.mem[17]});
    $display("move test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_trap;
    t_check;
    t_move;
    final_report;
  end
  // All three programs need well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    final_report;
  end
endmodule // cpu_xfer_core_tb_top
